// ===== include/iovg_pkg.sv
// Constants shared by the I/O violation guard
package iovg_pkg;

    // ------------------------------------------------------------
    // Register map (word offsets as byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_STATUS  = 8'h00;
    localparam logic [7:0]  ADDR_MASK    = 8'h04;
    localparam logic [7:0]  ADDR_CONTROL = 8'h08;
    localparam logic [7:0]  ADDR_STATE   = 8'h0c;
    localparam logic [7:0]  ADDR_TRAP    = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned EVT_VIOLATION   = 0;
    localparam int unsigned EVT_PROTECT_OFF = 1;
    localparam int unsigned EVT_WIDTH       = 2;

    localparam int unsigned CTL_PROTECT_ON  = 0;
    localparam int unsigned CTL_CLR_VIOL    = 1;

    localparam int unsigned ST_PROTECT_OFF  = 0;
    localparam int unsigned ST_VIOLATION    = 1;
    localparam int unsigned ST_LATCH        = 2;
    localparam int unsigned ST_ACTIVE       = 3;
    localparam int unsigned ST_WINDOW       = 4;
    localparam int unsigned ST_THIRD_PHASE  = 5;
    localparam int unsigned ST_TRAP_IOG     = 6;
    localparam int unsigned ST_TRAP_HALT    = 7;

    // I/O time slots, one-hot T1..T6
    localparam int unsigned SLOT_T1 = 0;
    localparam int unsigned SLOT_T3 = 2;
    localparam int unsigned SLOT_T4 = 3;
    localparam int unsigned SLOT_T5 = 4;
    localparam int unsigned SLOT_T6 = 5;

    // Instruction word fields
    localparam int unsigned IW_TOP      = 15;
    localparam int unsigned IW_GRP_HI   = 14;
    localparam int unsigned IW_GRP_LO   = 12;
    localparam int unsigned IW_IO_BIT   = 10;
    localparam int unsigned IW_OP_HI    = 8;
    localparam int unsigned IW_OP_LO    = 6;
    localparam logic [2:0]  IW_GRP_IO   = 3'h0;
    localparam logic [2:0]  IW_OP_HALT  = 3'h0;

    // Select code that stays reachable under protection
    localparam logic [5:0]  SELECT_CODE_SWITCH = 6'h01;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic             RST_PROTECT_OFF = 1'b1;
    localparam logic [EVT_WIDTH-1:0] RST_MASK    = 2'h0;
    localparam logic [15:0]      RST_TRAP        = 16'h0000;

endpackage

// ===== hdl/iovg_io_violation_guard.sv
// I/O violation guard of the memory protect unit
// What this block does
// - Microcode with strobe sets latch, T3..T6
// - Protection off: permit any I/O, T3..T6
// - Protection on: permit select code 01 only
// - Other codes blocked, violation set at T3
// - Interrupt fetch clears third-phase flop
// - Window from fetch end to phase+1 clock
// - Window, non-I/O trap: protection off T3
// - Window, non-halt I/O trap: protection stays
// - Window, halt trap: protection off T3
// - Trap word loaded at T4 of fetch
`timescale 1ns/1ps

module iovg_io_violation_guard
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [5:0]  IO_TIME_SLOT,
    input  wire logic        IO_GROUP_MICROCODE,
    input  wire logic        PHASE_ENABLE_STROBE,
    input  wire logic [5:0]  SELECT_CODE,
    input  wire logic        INTERRUPT_FETCH_PHASE,
    input  wire logic        NORMAL_FETCH_PHASE,
    input  wire logic        THIRD_PHASE_SET,
    input  wire logic [15:0] TRAP_WORD,
    input  wire logic        VIOLATION_SERVICE_CLEAR,
    input  wire logic        PROTECT_ENABLE,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [31:0]      REG_RDATA,
    output logic             IO_INSTRUCTION_PERMIT,
    output logic             IO_GROUP_ACTIVE,
    output logic             PROTECT_OFF_FLOP,
    output logic             PROTECT_VIOLATION_FLOP,
    output logic             THIRD_PHASE_STATUS_FLOP,
    output logic             IRQ
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                                 io_group_latch_ff;
    logic                                 nxt_io_group_latch;
    logic                                 protect_off_ff;
    logic                                 nxt_protect_off;
    logic                                 violation_ff;
    logic                                 nxt_violation;
    logic                                 third_phase_ff;
    logic                                 nxt_third_phase;
    logic                                 window_ff;
    logic                                 nxt_window;
    logic                                 int_fetch_d_ff;
    logic [15:0]                          trap_ff;
    logic [15:0]                          nxt_trap;
    logic [iovg_pkg::EVT_WIDTH-1:0]       status_ff;
    logic [iovg_pkg::EVT_WIDTH-1:0]       nxt_status;
    logic [iovg_pkg::EVT_WIDTH-1:0]       mask_ff;
    logic [iovg_pkg::EVT_WIDTH-1:0]       nxt_mask;
    logic [31:0]                          rdata_ff;
    logic [31:0]                          nxt_rdata;

    wire logic        slot_t3;
    wire logic        slot_t4;
    wire logic        slot_t6;
    wire logic        slot_t3_to_t6;
    wire logic        latch_set;
    wire logic        io_active;
    wire logic        select_code_one_hit;
    wire logic        permit;
    wire logic        violation_hit;
    wire logic        fetch_falls;
    wire logic        fetch_rises;
    wire logic        trap_is_iog;
    wire logic        trap_is_halt;
    wire logic        trap_turns_off;
    wire logic        off_event;
    wire logic        wr_mask;
    wire logic        wr_control;
    wire logic        rd_status;
    wire logic        ctl_protect_on;
    wire logic        ctl_clr_viol;
    wire logic        protect_on_req;
    wire logic        viol_clear_req;
    wire logic [iovg_pkg::EVT_WIDTH-1:0] events;
    wire logic [31:0] state_word;
    wire logic [31:0] rd_mux;
    wire logic        irq_pending;

    // ------------------------------------------------------------
    // Slot decode
    // ------------------------------------------------------------
    assign slot_t3 = IO_TIME_SLOT[iovg_pkg::SLOT_T3];
    assign slot_t4 = IO_TIME_SLOT[iovg_pkg::SLOT_T4];
    assign slot_t6 = IO_TIME_SLOT[iovg_pkg::SLOT_T6];
    assign slot_t3_to_t6 = |IO_TIME_SLOT[iovg_pkg::SLOT_T6:
                                         iovg_pkg::SLOT_T3];

    // ------------------------------------------------------------
    // I/O group latch
    // ------------------------------------------------------------
    assign latch_set = IO_GROUP_MICROCODE & PHASE_ENABLE_STROBE;

    // Set wins over the end-of-T6 clear for back-to-back instructions
    assign nxt_io_group_latch = latch_set ? 1'b1 :
                                (slot_t6 ? 1'b0 : io_group_latch_ff);

    // Gated by slot so the decoder only sees T3 through T6
    assign io_active = io_group_latch_ff & slot_t3_to_t6;

    // ------------------------------------------------------------
    // Permit and violation
    // ------------------------------------------------------------
    assign select_code_one_hit =
        (SELECT_CODE == iovg_pkg::SELECT_CODE_SWITCH);

    // Cards rely on this gate alone to ignore blocked I/O
    assign permit = io_active &
                    (protect_off_ff | select_code_one_hit);

    assign violation_hit = io_active & slot_t3 & ~protect_off_ff &
                           ~select_code_one_hit;

    assign viol_clear_req = VIOLATION_SERVICE_CLEAR | ctl_clr_viol;

    // Hardware set wins over a same-cycle service clear
    assign nxt_violation = violation_hit ? 1'b1 :
                           (viol_clear_req ? 1'b0 : violation_ff);

    // ------------------------------------------------------------
    // Phase tracking and post-interrupt window
    // ------------------------------------------------------------
    assign fetch_rises = INTERRUPT_FETCH_PHASE & ~int_fetch_d_ff;
    assign fetch_falls = ~INTERRUPT_FETCH_PHASE & int_fetch_d_ff;

    assign nxt_third_phase = fetch_rises ? 1'b0 :
                             (THIRD_PHASE_SET ? 1'b1 :
                              third_phase_ff);

    // Open at fetch end, close one clock after normal fetch starts
    assign nxt_window = fetch_falls ? 1'b1 :
                        (NORMAL_FETCH_PHASE ? 1'b0 : window_ff);

    assign nxt_trap = (INTERRUPT_FETCH_PHASE & slot_t4) ?
                      TRAP_WORD : trap_ff;

    // ------------------------------------------------------------
    // Trap classification and protect-off decision
    // ------------------------------------------------------------
    assign trap_is_iog =
        trap_ff[iovg_pkg::IW_TOP] &
        (trap_ff[iovg_pkg::IW_GRP_HI:iovg_pkg::IW_GRP_LO] ==
         iovg_pkg::IW_GRP_IO) &
        trap_ff[iovg_pkg::IW_IO_BIT];

    assign trap_is_halt = trap_is_iog &
        (trap_ff[iovg_pkg::IW_OP_HI:iovg_pkg::IW_OP_LO] ==
         iovg_pkg::IW_OP_HALT);

    // Non-halt I/O in the trap cell keeps protection armed
    assign trap_turns_off = ~trap_is_iog | trap_is_halt;

    assign off_event = window_ff & slot_t3 & trap_turns_off;

    assign protect_on_req = PROTECT_ENABLE | ctl_protect_on;

    // Interrupt-driven disable wins over a same-cycle enable request
    assign nxt_protect_off = off_event ? 1'b1 :
                             (protect_on_req ? 1'b0 : protect_off_ff);

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // Status writes are ignored; only a read clears it
    assign wr_mask    = REG_WR & (REG_ADDR == iovg_pkg::ADDR_MASK);
    assign wr_control = REG_WR & (REG_ADDR == iovg_pkg::ADDR_CONTROL);
    assign rd_status  = REG_RD & (REG_ADDR == iovg_pkg::ADDR_STATUS);

    assign ctl_protect_on = wr_control &
                            REG_WDATA[iovg_pkg::CTL_PROTECT_ON];
    assign ctl_clr_viol   = wr_control &
                            REG_WDATA[iovg_pkg::CTL_CLR_VIOL];

    assign events[iovg_pkg::EVT_VIOLATION]   = violation_hit;
    assign events[iovg_pkg::EVT_PROTECT_OFF] = off_event;

    // Status is read-to-clear; a new event in the read cycle survives
    assign nxt_status = events | (rd_status ? '0 : status_ff);

    assign nxt_mask = wr_mask ? REG_WDATA[iovg_pkg::EVT_WIDTH-1:0] :
                      mask_ff;

    // Debug view; bits above the flags read as zero
    assign state_word = {24'h000000,
                         trap_is_halt,
                         trap_is_iog,
                         third_phase_ff,
                         window_ff,
                         io_active,
                         io_group_latch_ff,
                         violation_ff,
                         protect_off_ff};

    assign rd_mux =
        (REG_ADDR == iovg_pkg::ADDR_STATUS)  ?
            {30'h00000000, status_ff} :
        (REG_ADDR == iovg_pkg::ADDR_MASK)    ?
            {30'h00000000, mask_ff} :
        (REG_ADDR == iovg_pkg::ADDR_CONTROL) ?
            {31'h00000000, ~protect_off_ff} :
        (REG_ADDR == iovg_pkg::ADDR_STATE)   ? state_word :
        (REG_ADDR == iovg_pkg::ADDR_TRAP)    ?
            {16'h0000, trap_ff} :
        32'h00000000;

    // Read data valid only in the cycle after the strobe
    assign nxt_rdata = REG_RD ? rd_mux : 32'h00000000;

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    // Level output, so software must read status or clear the mask to drop it
    assign irq_pending = |(status_ff & mask_ff);

    // ------------------------------------------------------------
    // Flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            io_group_latch_ff <= 1'b0;
            protect_off_ff    <= iovg_pkg::RST_PROTECT_OFF;
            violation_ff      <= 1'b0;
            third_phase_ff    <= 1'b0;
            window_ff         <= 1'b0;
            int_fetch_d_ff    <= 1'b0;
            trap_ff           <= iovg_pkg::RST_TRAP;
        end
        else
        begin
            io_group_latch_ff <= nxt_io_group_latch;
            protect_off_ff    <= nxt_protect_off;
            violation_ff      <= nxt_violation;
            third_phase_ff    <= nxt_third_phase;
            window_ff         <= nxt_window;
            int_fetch_d_ff    <= INTERRUPT_FETCH_PHASE;
            trap_ff           <= nxt_trap;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            status_ff <= '0;
            mask_ff   <= iovg_pkg::RST_MASK;
            rdata_ff  <= 32'h00000000;
        end
        else
        begin
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            rdata_ff  <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign REG_RDATA               = rdata_ff;
    assign IO_INSTRUCTION_PERMIT   = permit;
    assign IO_GROUP_ACTIVE         = io_active;
    assign PROTECT_OFF_FLOP        = protect_off_ff;
    assign PROTECT_VIOLATION_FLOP  = violation_ff;
    assign THIRD_PHASE_STATUS_FLOP = third_phase_ff;
    assign IRQ                     = irq_pending;

endmodule // iovg_io_violation_guard

// ===== sim/iovg_card_model.sv
// Behavioural model of an I/O interface card on the far side
`timescale 1ns/1ps
module iovg_card_model
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       io_permit,
    input  wire logic [5:0] slot,
    output logic      [7:0] acts
);
    // Counts one action per instruction, taken in T3 only
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            acts <= 8'h00;
        else if (io_permit && slot[2])
            acts <= acts + 8'h01;
endmodule // iovg_card_model

// ===== sim/iovg_io_violation_guard_asserts.sv
// Concurrent checks on the I/O violation guard ports
`timescale 1ns/1ps
module iovg_guard_chk
(
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic [5:0]  IO_TIME_SLOT,
    input wire logic [5:0]  SELECT_CODE,
    input wire logic        INTERRUPT_FETCH_PHASE,
    input wire logic        VIOLATION_SERVICE_CLEAR,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        IO_INSTRUCTION_PERMIT,
    input wire logic        IO_GROUP_ACTIVE,
    input wire logic        PROTECT_OFF_FLOP,
    input wire logic        PROTECT_VIOLATION_FLOP,
    input wire logic        THIRD_PHASE_STATUS_FLOP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire sc_one = SELECT_CODE == iovg_pkg::SELECT_CODE_SWITCH;
    // Software clear path also releases the flop
    wire ctl_clr = REG_WR && REG_ADDR == iovg_pkg::ADDR_CONTROL
                   && REG_WDATA[iovg_pkg::CTL_CLR_VIOL];
    a_active_in_slots: assert property (IO_GROUP_ACTIVE |->
        (IO_TIME_SLOT & 6'h3c) != 6'h00) else $error("active outside T3-T6");
    a_permit_needs_active: assert property (IO_INSTRUCTION_PERMIT
        |-> IO_GROUP_ACTIVE) else $error("permit without active");
    a_permit_when_off: assert property (IO_GROUP_ACTIVE &&
        PROTECT_OFF_FLOP |-> IO_INSTRUCTION_PERMIT) else $error("no permit");
    a_permit_code_one: assert property (IO_GROUP_ACTIVE &&
        !PROTECT_OFF_FLOP |-> IO_INSTRUCTION_PERMIT == sc_one)
        else $error("permit wrong under protection");
    a_violation_set: assert property (IO_GROUP_ACTIVE &&
        !PROTECT_OFF_FLOP && !sc_one && IO_TIME_SLOT[2]
        |=> PROTECT_VIOLATION_FLOP) else $error("violation not set");
    a_violation_holds: assert property (PROTECT_VIOLATION_FLOP &&
        !VIOLATION_SERVICE_CLEAR && !ctl_clr |=> PROTECT_VIOLATION_FLOP)
        else $error("violation dropped");
    a_third_cleared: assert property ($rose(INTERRUPT_FETCH_PHASE)
        |=> !THIRD_PHASE_STATUS_FLOP) else $error("third phase not cleared");
    a_off_only_t3: assert property (!PROTECT_OFF_FLOP &&
        !IO_TIME_SLOT[2] && !REG_WR |=> !PROTECT_OFF_FLOP)
        else $error("protection dropped outside T3");
    c_violation: cover property ($rose(PROTECT_VIOLATION_FLOP));
    c_protect_off: cover property ($rose(PROTECT_OFF_FLOP));
    c_permit: cover property (IO_INSTRUCTION_PERMIT && !PROTECT_OFF_FLOP);
endmodule // iovg_guard_chk

bind iovg_io_violation_guard iovg_guard_chk i_iovg_guard_chk (
    .CLK                     (CLK),
    .RST_N                   (RST_N),
    .IO_TIME_SLOT            (IO_TIME_SLOT),
    .SELECT_CODE             (SELECT_CODE),
    .INTERRUPT_FETCH_PHASE   (INTERRUPT_FETCH_PHASE),
    .VIOLATION_SERVICE_CLEAR (VIOLATION_SERVICE_CLEAR),
    .REG_ADDR                (REG_ADDR),
    .REG_WDATA               (REG_WDATA),
    .REG_WR                  (REG_WR),
    .IO_INSTRUCTION_PERMIT   (IO_INSTRUCTION_PERMIT),
    .IO_GROUP_ACTIVE         (IO_GROUP_ACTIVE),
    .PROTECT_OFF_FLOP        (PROTECT_OFF_FLOP),
    .PROTECT_VIOLATION_FLOP  (PROTECT_VIOLATION_FLOP),
    .THIRD_PHASE_STATUS_FLOP (THIRD_PHASE_STATUS_FLOP)
);

// ===== sim/iovg_io_violation_guard_tb.sv
// Self-checking testbench for the I/O violation guard
`timescale 1ns/1ps
module iovg_io_violation_guard_tb;
    typedef struct packed {logic on; logic [5:0] sc; logic ep;} iovg_row_s;
    logic        clk = 1'b0, rst_n = 1'b0, mc = 1'b0, stb = 1'b0;
    logic        fetch = 1'b0, nfetch = 1'b0, tset = 1'b0, vclr = 1'b0;
    logic        pen = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [5:0]  slot = 6'h00, sc = 6'h00;
    logic [15:0] trap = 16'h0000;
    logic [7:0]  addr = 8'h00, acts;
    logic [31:0] wdata = 32'h0, rdata;
    logic        permit, active, poff, viol, third, irq;
    int          failures = 0, n_tests = 0;
    iovg_row_s   rows [6] = '{'{1'b0, 6'h05, 1'b1}, '{1'b0, 6'h01, 1'b1},
        '{1'b1, 6'h01, 1'b1}, '{1'b1, 6'h02, 1'b0}, '{1'b1, 6'h00, 1'b0},
        '{1'b1, 6'h3f, 1'b0}};
    logic [15:0] traps [3] = '{16'h0000, 16'h8400, 16'h8440};
    logic        toff [3] = '{1'b1, 1'b1, 1'b0};
    logic [7:0]  stw [3] = '{8'h01, 8'hc1, 8'h40};
    always #4 clk = ~clk;
    iovg_io_violation_guard i_iovg_io_violation_guard (.CLK(clk),
        .RST_N(rst_n), .IO_TIME_SLOT(slot), .IO_GROUP_MICROCODE(mc),
        .PHASE_ENABLE_STROBE(stb), .SELECT_CODE(sc),
        .INTERRUPT_FETCH_PHASE(fetch), .NORMAL_FETCH_PHASE(nfetch),
        .THIRD_PHASE_SET(tset), .TRAP_WORD(trap),
        .VIOLATION_SERVICE_CLEAR(vclr), .PROTECT_ENABLE(pen),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .IO_INSTRUCTION_PERMIT(permit),
        .IO_GROUP_ACTIVE(active), .PROTECT_OFF_FLOP(poff),
        .PROTECT_VIOLATION_FLOP(viol), .THIRD_PHASE_STATUS_FLOP(third),
        .IRQ(irq));
    iovg_card_model i_iovg_card_model (.clk(clk), .rst_n(rst_n),
        .io_permit(permit), .slot(slot), .acts(acts));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input logic [5:0] s);
        @(posedge clk);
        slot <= s;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic pulse_on();
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        pen <= 1'b0;
    endtask
    // One I/O instruction across T1..T6, then a bare T3 afterwards
    task automatic io_instr(input logic [5:0] s, input logic ep);
        logic [7:0] a0;
        a0 = acts;
        @(posedge clk);
        sc <= s;
        mc <= 1'b1;
        stb <= 1'b1;
        slot <= 6'h01;
        @(posedge clk);
        mc <= 1'b0;
        stb <= 1'b0;
        slot <= 6'h02;
        cyc(6'h04);
        #1 chk(active, 1'b1);
        chk(permit, ep);
        cyc(6'h08);
        #1 chk(viol, !ep);
        chk(acts, a0 + 8'(ep));
        for (int k = 4; k < 7; k++)
            cyc(6'h01 << (k % 6));
        cyc(6'h04);
        #1 chk(active, 1'b0);
        chk(viol, !ep);
    endtask
    // Watchdog: the whole run needs under two hundred cycles
    initial
    begin
        #40000;
        failures++;
        report_and_stop();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        #1 chk(poff, 1'b1);
        chk({irq, permit, viol}, 32'h0);
        chk(rdata, 32'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].on)
                pulse_on();
            io_instr(rows[i].sc, rows[i].ep);
            @(posedge clk);
            vclr <= 1'b1;
            @(posedge clk);
            vclr <= 1'b0;
            #1 chk(viol, 1'b0);
        end
        wr_reg(8'h04, 32'h3);
        chk(irq, 1'b1);
        rd_reg(8'h00, 32'h1);
        chk(irq, 1'b0);
        rd_reg(8'h00, 32'h0);
        rd_reg(8'h04, 32'h3);
        rd_reg(8'h20, 32'h0);
        rd_reg(8'h08, 32'h1);
        io_instr(6'h02, 1'b0);
        wr_reg(8'h04, 32'h0);
        chk(irq, 1'b0);
        wr_reg(8'h08, 32'h2);
        chk(viol, 1'b0);
        rd_reg(8'h00, 32'h1);
        foreach (traps[i])
        begin
            if (i == 1)
                wr_reg(8'h08, 32'h1);
            else
                pulse_on();
            @(posedge clk);
            tset <= 1'b1;
            @(posedge clk);
            tset <= 1'b0;
            #1 chk(third, 1'b1);
            @(posedge clk);
            fetch <= 1'b1;
            trap <= traps[i];
            for (int k = 0; k < 6; k++)
                cyc(6'h01 << k);
            #1 chk(third, 1'b0);
            cyc(6'h01);
            fetch <= 1'b0;
            cyc(6'h02);
            #1 chk(poff, 1'b0);
            cyc(6'h04);
            cyc(6'h08);
            #1 chk(poff, toff[i]);
            cyc(6'h10);
            nfetch <= 1'b1;
            cyc(6'h20);
            nfetch <= 1'b0;
            rd_reg(8'h10, {16'h0, traps[i]});
            rd_reg(8'h00, {30'h0, toff[i], 1'b0});
            rd_reg(8'h0c, {24'h0, stw[i]});
        end
        // Reset in mid-run must re-open I/O with protection off
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1 chk(poff, 1'b1);
        chk({irq, third, viol}, 32'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk({permit, active, viol}, 32'h0);
        chk(poff, 1'b1);
        report_and_stop();
    end
endmodule // iovg_io_violation_guard_tb
